// ==== include/bpf_pkg.sv ====
// Shared constants for the battery protector fault logic
package bpf_pkg;
   // Threshold codes that switch off the severe checks
   localparam logic [7:0] BPF_OV_DISABLE_CODE = 8'hF8;
   localparam logic [3:0] BPF_HOT_DISABLE_CODE = 4'hF;
   // Charger detect offset in millivolts
   localparam int BPF_CHG_DET_OFFSET_MV = 150;
   localparam int BPF_MV_W = 16;
   localparam logic [BPF_MV_W-1:0] BPF_CHG_DET_OFFSET =
      BPF_MV_W'(BPF_CHG_DET_OFFSET_MV);
   // Nonvolatile failure status bit positions
   localparam int BPF_ST_SUMMARY = 0;
   localparam int BPF_ST_OUT_SHORT = 1;
   localparam int BPF_ST_IN_SHORT = 2;
   localparam int BPF_ST_OPEN = 3;
   localparam int BPF_ST_OV = 4;
   localparam int BPF_ST_OT = 5;
   localparam int BPF_ST_SUM = 6;
   localparam int BPF_ST_W = 7;
   localparam int BPF_NFAULT = 6;
   localparam logic [BPF_ST_W-1:0] BPF_ST_RESET = 7'h00;
   // Debounce counter width and checksum width
   localparam int BPF_DEB_W = 16;
   localparam int BPF_SUM_W = 16;
   localparam int BPF_CFG_W = 16;
   typedef enum logic [2:0] {
      BPF_SUSP_NONE = 3'b001,
      BPF_SUSP_FULL = 3'b010,
      BPF_SUSP_WDOG = 3'b100
   } bpf_susp_t;
endpackage

// ==== verilog/bpf_debounce.sv ====
// Per-fault persistence filter for permanent failure detection
`timescale 1ns/1ps
`default_nettype none
module bpf_debounce
   import bpf_pkg::*;
#(
   parameter int WIDTH = BPF_DEB_W
) (
   // Clock and control
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Condition and limit
   input wire logic cond,
   input wire logic [WIDTH-1:0] limit,
   // Result
   output logic expired
);
   if (WIDTH < 1) begin : g_bad_width
      $error("bpf_debounce: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] count;
   wire at_limit = (count > limit);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count <= '0;
      end else if (clk_en) begin
         if (!cond) begin
            count <= '0;
         end else if (!at_limit) begin
            count <= count + WIDTH'(1);
         end
      end
   end

   // Must persist longer than the debounce time
   assign expired = cond && at_limit;
endmodule
`default_nettype wire

// ==== verilog/bpf_protector.sv ====
// Charge and discharge switch control with suspend and permanent failure handling
//
// Notes on behaviour
// - Full-suspend enabled and termination met turns charge switch off, flags full suspend.
// - Watchdog enabled and host timeout turns charge switch off, flags watchdog suspend.
// - Full suspend releases on discharge or charger removal.
// - Watchdog suspend releases on host activity, discharge or charger removal.
// - Charge current with charge switch off is a failure and blows fuse.
// - Discharge current with discharge switch off is a failure and blows fuse.
// - Any permanent failure forces both switches off, held across power cycles.
// - Permanent failure status is stored in nonvolatile status.
// - Permanent failure drives fuse output high.
// - Failure needs global enable and condition longer than debounce time.
// - Summary flag set together with the specific fault flag.
// - Switch open and short checks run only when check enable is set.
// - Discharge seen with discharge switch off sets outflow shorted flag.
// - Charge seen with charge switch off sets inflow shorted flag.
// - Discharge switch on, pack low, no discharge current sets open flag.
// - Both on, pack above cell by threshold, no charge current sets open flag.
// - Cell voltage above severe threshold sets overvoltage flag; code F8 disables.
// - Temperature above severe hot threshold sets overtemp flag; max code disables.
// - Startup checksum compare when enabled; mismatch sets checksum flag.
// - Pin override with alert low forces both switches off while low.
// - Command override turns off only the commanded switch.
// - Removing an override restores switches to fault state, not forced on.
// - Charging detected by current, average current, or pack above cell by 0.15V.
// - Discharging detected by negative currents or pack falling below cell plus 0.15V.
`timescale 1ns/1ps
`default_nettype none
module bpf_protector
   import bpf_pkg::*;
#(
   parameter int DEB_W = BPF_DEB_W,
   parameter int CUR_W = 16
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Measurements (signed currents, millivolt voltages)
   input wire logic signed [CUR_W-1:0] current,
   input wire logic signed [CUR_W-1:0] avg_current,
   input wire logic [BPF_MV_W-1:0] cell_voltage,
   input wire logic [7:0] cell_voltage_code,
   input wire logic [3:0] temperature_code,
   input wire logic [BPF_MV_W-1:0] pack_plus_pin,
   input wire logic [BPF_MV_W-1:0] cell_plus_pin,
   input wire logic pack_low,
   // Detection thresholds
   input wire logic [CUR_W-2:0] current_detect_threshold,
   input wire logic [CUR_W-2:0] average_detect_threshold,
   input wire logic [BPF_MV_W-1:0] charger_detect_threshold,
   input wire logic [7:0] severe_overvoltage_threshold,
   input wire logic [3:0] severe_hot_threshold,
   // Configuration
   input wire logic full_suspend_enable,
   input wire logic charge_watchdog_enable,
   input wire logic perm_failure_enable,
   input wire logic switch_failure_check_enable,
   input wire logic config_sum_check_enable,
   input wire logic pin_override_enable,
   input wire logic command_override_enable,
   input wire logic [DEB_W-1:0] perm_failure_debounce,
   input wire logic [BPF_CFG_W-1:0] protector_config,
   input wire logic [BPF_SUM_W-1:0] stored_config_sum,
   // Events and host
   input wire logic charge_terminated,
   input wire logic host_timeout,
   input wire logic host_activity,
   input wire logic inflow_off_command,
   input wire logic outflow_off_command,
   input wire logic alert_pin,
   // Nonvolatile status restored at power-up
   input wire logic [BPF_ST_W-1:0] nv_failure_status_in,
   input wire logic nv_status_valid,
   // Outputs
   output logic inflow_switch_enable,
   output logic outflow_switch_enable,
   output logic fuse_drive_output,
   output logic [BPF_ST_W-1:0] nv_failure_status,
   output logic nv_write_strobe,
   output logic full_suspend_flag,
   output logic watchdog_suspend_flag
);
   // Refuse widths that leave no room for a count or a signed magnitude
   if (DEB_W < 1 || CUR_W < 2) begin : g_bad_param
      $error("bpf_protector: width parameters too small");
   end

   ////////////////////////////////////////////////////////////////////////
   // Alert pin synchroniser: three stages, change accepted when 2 and 3 agree
   logic [2:0] alert_sync;
   logic alert_low;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         alert_sync <= 3'h7;
         alert_low <= 1'b0;
      end else if (clk_en) begin
         alert_sync <= {alert_sync[1:0], alert_pin};
         if (alert_sync[2] == alert_sync[1]) begin
            alert_low <= ~alert_sync[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Charge / discharge detection
   wire signed [CUR_W-1:0] cur_det = $signed({1'b0, current_detect_threshold});
   wire signed [CUR_W-1:0] avg_det = $signed({1'b0, average_detect_threshold});
   wire [BPF_MV_W:0] cell_plus_ofs = {1'b0, cell_plus_pin} + {1'b0, BPF_CHG_DET_OFFSET};
   wire [BPF_MV_W:0] cell_plus_chg = {1'b0, cell_plus_pin} + {1'b0, charger_detect_threshold};
   wire [BPF_MV_W:0] pack_ext = {1'b0, pack_plus_pin};
   wire charge_current = (current > cur_det) || (avg_current > avg_det);
   wire discharge_current = (current < -cur_det) || (avg_current < -avg_det);
   wire charging = charge_current || (pack_ext > cell_plus_ofs);
   wire pack_below = pack_ext < cell_plus_ofs;
   // Rising edge of pack_below (pack dropping under cell plus offset), so a static low pack is not a discharge
   // Resets as if the pack were already low, so leaving reset gives no false edge
   logic pack_below_d;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pack_below_d <= 1'b1;
      end else if (clk_en) begin
         pack_below_d <= pack_below;
      end
   end
   wire discharging = discharge_current || (pack_below && !pack_below_d);

   ////////////////////////////////////////////////////////////////////////
   // Charge suspend state machine
   bpf_susp_t susp, next_susp;
   always_comb begin
      next_susp = susp;
      unique case (susp)
         BPF_SUSP_NONE: begin
            if (full_suspend_enable && charge_terminated) begin
               next_susp = BPF_SUSP_FULL;
            end else if (charge_watchdog_enable && host_timeout) begin
               next_susp = BPF_SUSP_WDOG;
            end
         end
         BPF_SUSP_FULL: begin
            if (discharging || pack_below) begin
               next_susp = BPF_SUSP_NONE;
            end
         end
         BPF_SUSP_WDOG: begin
            if (host_activity || discharging || pack_below) begin
               next_susp = BPF_SUSP_NONE;
            end
         end
         default: next_susp = BPF_SUSP_NONE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         susp <= BPF_SUSP_NONE;
      end else if (clk_en) begin
         susp <= next_susp;
      end
   end
   assign full_suspend_flag = (susp == BPF_SUSP_FULL);
   assign watchdog_suspend_flag = (susp == BPF_SUSP_WDOG);

   ////////////////////////////////////////////////////////////////////////
   // Permanent failure conditions
   wire perm_latched = nv_failure_status[BPF_ST_SUMMARY];
   wire in_cmd_off = command_override_enable && inflow_off_command;
   wire out_cmd_off = command_override_enable && outflow_off_command;
   wire pin_off = pin_override_enable && alert_low;
   wire fsm_in_on = !perm_latched && (susp == BPF_SUSP_NONE);
   wire fsm_out_on = !perm_latched;
   // Overrides only mask the fault-state result, so release falls back to it
   wire in_on = fsm_in_on && !pin_off && !in_cmd_off;
   wire out_on = fsm_out_on && !pin_off && !out_cmd_off;
   wire chk = switch_failure_check_enable;
   logic [BPF_NFAULT-1:0] cond;
   logic sum_mismatch;
   assign cond[0] = chk && !out_on && discharging;
   assign cond[1] = chk && !in_on && charging;
   assign cond[2] = chk && ((out_on && pack_low && !discharge_current) ||
      (in_on && out_on && (pack_ext > cell_plus_chg) && !charge_current));
   assign cond[3] = (severe_overvoltage_threshold != BPF_OV_DISABLE_CODE) &&
      (cell_voltage_code > severe_overvoltage_threshold);
   assign cond[4] = (severe_hot_threshold != BPF_HOT_DISABLE_CODE) &&
      (temperature_code > severe_hot_threshold);
   assign cond[5] = sum_mismatch;

   logic [BPF_NFAULT-1:0] expired;
   genvar gi;
   generate
      for (gi = 0; gi < BPF_NFAULT; gi++) begin : g_deb
         bpf_debounce #(.WIDTH(DEB_W)) u_deb (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .cond(cond[gi] && perm_failure_enable),
            .limit(perm_failure_debounce),
            .expired(expired[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Startup checksum over the protector configuration
   logic sum_done;
   wire [BPF_SUM_W-1:0] cfg_sum = protector_config ^ BPF_SUM_W'(16'hA5A5);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sum_done <= 1'b0;
         sum_mismatch <= 1'b0;
      end else if (clk_en && nv_status_valid && !sum_done) begin
         sum_done <= 1'b1;
         sum_mismatch <= config_sum_check_enable && (cfg_sum != stored_config_sum);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nonvolatile failure status: restored once, then only accumulates
   logic loaded;
   wire any_new = |expired;
   wire [BPF_ST_W-1:0] new_bits = {expired[5], expired[4], expired[3],
      expired[2], expired[1], expired[0], any_new};
   wire [BPF_ST_W-1:0] next_status = nv_failure_status | new_bits;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         loaded <= 1'b0;
         nv_failure_status <= BPF_ST_RESET;
         nv_write_strobe <= 1'b0;
      end else if (clk_en) begin
         nv_write_strobe <= 1'b0;
         if (!loaded) begin
            if (nv_status_valid) begin
               loaded <= 1'b1;
               nv_failure_status <= nv_failure_status_in;
            end
         end else if (next_status != nv_failure_status) begin
            nv_failure_status <= next_status;
            nv_write_strobe <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; switches stay off until the stored status is known
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         inflow_switch_enable <= 1'b0;
         outflow_switch_enable <= 1'b0;
         fuse_drive_output <= 1'b0;
      end else if (clk_en) begin
         inflow_switch_enable <= loaded && in_on && !any_new;
         outflow_switch_enable <= loaded && out_on && !any_new;
         fuse_drive_output <= perm_latched || any_new;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_PERM_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && perm_latched |=> !inflow_switch_enable && !outflow_switch_enable)
      else $error("switch on after permanent failure");
   AST_FUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && perm_latched |=> fuse_drive_output)
      else $error("fuse drive low after permanent failure");
   AST_SUMMARY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(|nv_failure_status[BPF_ST_W-1:1]) && $past(loaded) |-> nv_failure_status[BPF_ST_SUMMARY])
      else $error("specific fault without summary");
   AST_NO_PF_WHEN_DIS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !perm_failure_enable && loaded && clk_en |=> $stable(nv_failure_status))
      else $error("failure recorded while disabled");
   AST_PIN_OVR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && pin_off |=> !inflow_switch_enable && !outflow_switch_enable)
      else $error("switch on during pin override");
   AST_CMD_OVR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && in_cmd_off |=> !inflow_switch_enable)
      else $error("inflow on during command override");
   AST_FULL_SUSP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && susp == BPF_SUSP_NONE && full_suspend_enable && charge_terminated
      |=> full_suspend_flag)
      else $error("full suspend not entered");
   AST_WDOG_REL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && watchdog_suspend_flag && host_activity |=> !watchdog_suspend_flag)
      else $error("watchdog suspend not released");
   AST_SUSP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && susp != BPF_SUSP_NONE |=> !inflow_switch_enable)
      else $error("inflow on during suspend");
   COV_PERM: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(fuse_drive_output));
   COV_WDOG: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(watchdog_suspend_flag));
   COV_PIN: cover property (@(posedge ref_clk) disable iff (!rst_n) pin_off ##1 !pin_off);
endmodule
`default_nettype wire

// ==== verif/bpf_pack_model.sv ====
// Pack model: switches, cell, charger and load as seen by the protector
`timescale 1ns/1ps
`default_nettype none
module bpf_pack_model (
   // Switch gates
   input wire logic inflow_en,
   input wire logic outflow_en,
   // Scenario controls
   input wire logic charger,
   input wire logic load,
   input wire logic shorted,
   input wire logic opened,
   // Measured quantities
   output logic signed [15:0] current,
   output logic [15:0] pack_mv,
   output logic [15:0] cell_mv,
   output logic pack_low
);
   wire logic in_path;
   wire logic out_path;
   // A shorted switch conducts whatever its gate says; an open one never does
   assign in_path = (inflow_en | shorted) & ~opened;
   assign out_path = (outflow_en | shorted) & ~opened;
   assign cell_mv = 16'h0ED8;
   assign current = (charger & in_path) ? 16'sh01F4 : (load & out_path) ? -16'sh01F4 : 16'sh0000;
   // The charger sits on the pack pin whatever the switches do
   assign pack_mv = charger ? 16'h1388 : (out_path ? cell_mv : 16'h0000);
   assign pack_low = pack_mv < 16'h03E8;
endmodule
`default_nettype wire

// ==== verif/tb_bpf_protector.sv ====
// Self-checking bench for the protector fault logic
`timescale 1ns/1ps
`default_nettype none
module tb_bpf_protector;
   import bpf_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, pack_low, nv_status_valid = 1'b0;
   logic signed [15:0] current, avg_current;
   logic [15:0] cell_voltage, pack_plus_pin, cell_plus_pin;
   logic [7:0] cell_voltage_code = 8'h00, severe_overvoltage_threshold = 8'hF8, rnd;
   logic [3:0] temperature_code = 4'h0, severe_hot_threshold = 4'hF;
   logic [14:0] current_detect_threshold = 15'h0064, average_detect_threshold = 15'h0064;
   logic [15:0] charger_detect_threshold = 16'h0096, perm_failure_debounce = 16'h0004;
   logic [15:0] protector_config = 16'h0000, stored_config_sum = 16'hA5A5, cfg;
   logic full_suspend_enable = 1'b0, charge_watchdog_enable = 1'b0, perm_failure_enable = 1'b0;
   logic switch_failure_check_enable = 1'b0, config_sum_check_enable = 1'b1;
   logic pin_override_enable = 1'b0, command_override_enable = 1'b0;
   logic charge_terminated = 1'b0, host_timeout = 1'b0, host_activity = 1'b0;
   logic inflow_off_command = 1'b0, outflow_off_command = 1'b0, alert_pin = 1'b1;
   logic [BPF_ST_W-1:0] nv_failure_status_in = 7'h00, nv_failure_status, note;
   logic inflow_switch_enable, outflow_switch_enable, fuse_drive_output, nv_write_strobe;
   logic full_suspend_flag, watchdog_suspend_flag;
   logic charger = 1'b1, load = 1'b0, shorted = 1'b0, opened = 1'b0;
   logic [BPF_ST_W-1:0] exp_q[$];
   int num_errors = 0, total_checks = 0, cycles = 0, seed = 92953;
   int bits[10] = '{BPF_ST_OV, BPF_ST_OT, BPF_ST_IN_SHORT, BPF_ST_OPEN, BPF_ST_OUT_SHORT,
                  BPF_ST_SUM, -1, -1, -1, BPF_ST_OPEN};

   always #2.5 ref_clk = ~ref_clk;

   bpf_pack_model PM (.inflow_en(inflow_switch_enable), .outflow_en(outflow_switch_enable),
      .charger, .load, .shorted, .opened, .current, .pack_mv(pack_plus_pin),
      .cell_mv(cell_plus_pin), .pack_low);
   assign avg_current = current;
   assign cell_voltage = cell_plus_pin;
   bpf_protector #(.DEB_W(16), .CUR_W(16)) DUT (.ref_clk, .rst_n, .clk_en, .current,
      .avg_current, .cell_voltage, .cell_voltage_code, .temperature_code, .pack_plus_pin,
      .cell_plus_pin, .pack_low, .current_detect_threshold, .average_detect_threshold,
      .charger_detect_threshold, .severe_overvoltage_threshold, .severe_hot_threshold,
      .full_suspend_enable, .charge_watchdog_enable, .perm_failure_enable,
      .switch_failure_check_enable, .config_sum_check_enable, .pin_override_enable,
      .command_override_enable, .perm_failure_debounce, .protector_config, .stored_config_sum,
      .charge_terminated, .host_timeout, .host_activity, .inflow_off_command,
      .outflow_off_command, .alert_pin, .nv_failure_status_in, .nv_status_valid,
      .inflow_switch_enable, .outflow_switch_enable, .fuse_drive_output, .nv_failure_status,
      .nv_write_strobe, .full_suspend_flag, .watchdog_suspend_flag);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic chk_sw(input logic ei, input logic eo);
      chk("inflow_switch_enable", {15'h0000, ei}, {15'h0000, inflow_switch_enable});
      chk("outflow_switch_enable", {15'h0000, eo}, {15'h0000, outflow_switch_enable});
   endtask

   task automatic do_reset(input logic [BPF_ST_W-1:0] stored, input logic pf);
      rst_n <= 1'b0;
      nv_failure_status_in <= stored;
      perm_failure_enable <= pf;
      {full_suspend_enable, charge_watchdog_enable, switch_failure_check_enable} <= 3'h0;
      {pin_override_enable, command_override_enable} <= 2'h0;
      {inflow_off_command, outflow_off_command} <= 2'h0;
      {charge_terminated, host_timeout, host_activity, load, shorted, opened} <= 6'h00;
      {alert_pin, charger} <= 2'h3;
      {severe_overvoltage_threshold, cell_voltage_code} <= 16'hF800;
      {severe_hot_threshold, temperature_code} <= 8'hF0;
      step(8);
      rst_n <= 1'b1;
      step(1);
      nv_status_valid <= 1'b1;
      step(1);
      nv_status_valid <= 1'b0;
      step(3);
   endtask

   // Note goes in before reset: the checksum fault can strike during startup
   task automatic pf_case(input int k);
      logic [BPF_ST_W-1:0] exp;
      exp = (bits[k] < 0) ? 7'h00 : (7'h01 << bits[k]) | (7'h01 << BPF_ST_SUMMARY);
      cfg = 16'($random(seed));
      rnd = 8'h10 + 8'($unsigned($random(seed)) % 200);
      protector_config <= cfg;
      stored_config_sum <= cfg ^ 16'hA5A5 ^ {15'h0000, k == 5};
      if (exp != 7'h00) exp_q.push_back(exp);
      do_reset(7'h00, k != 7);
      case (k)
         0, 6, 7: begin
            severe_overvoltage_threshold <= (k == 6) ? 8'hF8 : rnd;
            cell_voltage_code <= (k == 6) ? 8'hFF : rnd + 8'h01;
         end
         1: begin
            severe_hot_threshold <= {1'b0, rnd[2:0]};
            temperature_code <= {1'b0, rnd[2:0]} + 4'h1;
         end
         2, 4, 8: begin
            switch_failure_check_enable <= (k != 8);
            command_override_enable <= 1'b1;
            shorted <= 1'b1;
            inflow_off_command <= (k != 4);
            outflow_off_command <= (k == 4);
            charger <= (k != 4);
            load <= (k == 4);
         end
         3, 9: begin
            // Without the charger the open path leaves the pack low
            switch_failure_check_enable <= 1'b1;
            opened <= 1'b1;
            charger <= (k == 3);
         end
         default: ;
      endcase
      step(3);
      if (k != 5) chk("fuse_drive_output", 16'h0000, {15'h0000, fuse_drive_output});
      for (int i = 0; i < 30 && fuse_drive_output !== 1'b1; i++) step(1);
      chk("fuse_drive_output", {15'h0000, exp != 7'h00}, {15'h0000, fuse_drive_output});
      // Dropping the enable stops follow-on faults once the switches go off
      perm_failure_enable <= 1'b0;
      step(2);
      if (exp != 7'h00) chk_sw(1'b0, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
      if (nv_write_strobe === 1'b1) begin
         if (exp_q.size() == 0) chk("nv_write_strobe", 16'h0000, 16'h0001);
         else begin
            note = exp_q.pop_front();
            chk("nv_failure_status", {9'h000, note}, {9'h000, nv_failure_status});
         end
      end
   end

   initial begin
      do_reset(7'h00, 1'b0);
      chk_sw(1'b1, 1'b1);
      full_suspend_enable <= 1'b1;
      charge_terminated <= 1'b1;
      step(3);
      chk_sw(1'b0, 1'b1);
      chk("full_suspend_flag", 16'h0001, {15'h0000, full_suspend_flag});
      charge_terminated <= 1'b0;
      charger <= 1'b0;
      load <= 1'b1;
      step(6);
      chk_sw(1'b1, 1'b1);
      chk("full_suspend_flag", 16'h0000, {15'h0000, full_suspend_flag});
      charger <= 1'b1;
      load <= 1'b0;
      charge_watchdog_enable <= 1'b1;
      host_timeout <= 1'b1;
      step(3);
      chk_sw(1'b0, 1'b1);
      chk("watchdog_suspend_flag", 16'h0001, {15'h0000, watchdog_suspend_flag});
      host_timeout <= 1'b0;
      host_activity <= 1'b1;
      step(3);
      chk_sw(1'b1, 1'b1);
      chk("watchdog_suspend_flag", 16'h0000, {15'h0000, watchdog_suspend_flag});
      host_activity <= 1'b0;
      alert_pin <= 1'b0;
      outflow_off_command <= 1'b1;
      step(6);
      chk_sw(1'b1, 1'b1);
      command_override_enable <= 1'b1;
      step(3);
      chk_sw(1'b1, 1'b0);
      outflow_off_command <= 1'b0;
      inflow_off_command <= 1'b1;
      step(3);
      chk_sw(1'b0, 1'b1);
      inflow_off_command <= 1'b0;
      pin_override_enable <= 1'b1;
      step(6);
      chk_sw(1'b0, 1'b0);
      charge_terminated <= 1'b1;
      alert_pin <= 1'b1;
      step(6);
      chk_sw(1'b0, 1'b1);
      for (int k = 0; k < 5; k++) pf_case(k);
      for (int k = 5; k < 10; k++) pf_case(k);
      do_reset(7'h05, 1'b1);
      step(2);
      chk_sw(1'b0, 1'b0);
      chk("nv_failure_status", 16'h0005, {9'h000, nv_failure_status});
      chk("fuse_drive_output", 16'h0001, {15'h0000, fuse_drive_output});
      chk("exp_q", 16'h0000, 16'(exp_q.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
